// ===== hdl/dsg_ctrl.sv
// Deserializer mode strap, GPIO routing, output strobe and power-down control
`timescale 1ns/1ps
module dsg_ctrl
  import dsg_pkg::*;
(
  input  wire logic                  clock_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  powerdown_n_pin_i,
  input  wire logic [1:0]            mode_strap_resistor_i,
  input  wire logic                  ext_osc_mode_i,
  input  wire logic                  cdr_locked_i,
  input  wire logic                  pclk_i,
  input  wire logic [DSG_DATA_W-1:0] rx_data_i,
  input  wire logic                  rx_line_sync_i,
  input  wire logic                  rx_frame_sync_i,
  input  wire logic                  rx_strobe_edge_sel_i,
  input  wire logic                  stagger_en_i,
  input  wire logic [DSG_GPIO_N-1:0] gpio_fwd_sel_i,
  input  wire logic [DSG_GPIO_N-1:0] gpio_local_val_i,
  input  wire logic [DSG_GPIO_N-1:0] gpio_in_i,
  input  wire logic [7:0]            reg_addr_i,
  input  wire logic [7:0]            reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic [7:0]                 reg_rdata_o,
  output logic [DSG_GPIO_N-1:0]      gpio_out_o,
  output logic [DSG_GPIO_N-1:0]      gpio_oe_n_o,
  output logic [DSG_GPIO_N-1:0]      link_gpio_o,
  output logic [DSG_DATA_W-1:0]      data_o,
  output logic                       line_sync_o,
  output logic                       frame_sync_o,
  output logic                       data_oe_n_o,
  output logic                       lock_o,
  output logic                       lock_oe_n_o,
  output logic                       link_enable_o,
  output logic [1:0]                 bc_mode_o,
  output logic                       bc_mode_send_o,
  output logic [1:0]                 clk_ratio_o,
  output logic [DSG_SSC_PROF_MSB:0]  ssc_profile_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    // Pin samples for edge detection
    logic                                 pdb_q;
    logic                                 pclk_q;
    // Held mode, clock ratio and back-channel request
    logic                                 mode_valid;
    dsg_mode_t                            mode;
    dsg_ratio_t                           ratio;
    logic                                 bc_send;
    // Register file and read data
    logic [7:0]                           ssc;
    logic [7:0]                           rdata;
    // Lock indicator and staggered output word
    logic                                 lock;
    logic                                 lock_oe_n;
    logic [DSG_OUT_W-1:0]                 outw;
    logic [DSG_OUT_W-1:0]                 pend;
    logic                                 late;
    logic                                 data_oe_n;
    // GPIO drive, forwarding and rate limit
    logic [DSG_GPIO_N-1:0]                gpio_out;
    logic [DSG_GPIO_N-1:0]                gpio_oe_n;
    logic [DSG_GPIO_N-1:0]                link_gpio;
    logic [DSG_GPIO_N-1:0][DSG_HOLD_W-1:0] hold;
    // Link enable
    logic                                 link_en;
  } dsg_state_t;

  // Values at reset and, except ssc and pclk_q, through power-down
  localparam dsg_state_t DSG_STATE_RESET = '{
    pdb_q:      1'b0,
    pclk_q:     1'b0,
    mode_valid: 1'b0,
    mode:       DSG_MODE_12LF,
    ratio:      DSG_RATIO_DIV1,
    bc_send:    1'b0,
    ssc:        DSG_SSC_CTRL_RESET,
    rdata:      DSG_RDATA_NONE,
    lock:       1'b0,
    lock_oe_n:  1'b1,
    outw:       '0,
    pend:       '0,
    late:       1'b0,
    data_oe_n:  1'b1,
    gpio_out:   '0,
    gpio_oe_n:  '1,
    link_gpio:  '0,
    hold:       '0,
    link_en:    1'b0
  };

  // Internal nets
  dsg_state_t           st_r;
  dsg_state_t           st_nxt;
  logic [DSG_OUT_W-1:0] stagger_mask;
  logic                 lfsr_run;

  // Mask source runs only while powered
  assign lfsr_run = st_r.pdb_q;

  // ----------------------------------------------------------------
  // Random stagger mask source
  // ----------------------------------------------------------------
  dsg_stagger_lfsr u_lfsr (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .run_i   (lfsr_run),
    .mask_o  (stagger_mask)
  );

  // ----------------------------------------------------------------
  // Local constants
  // ----------------------------------------------------------------
  // Pins two and three are lost to the oscillator
  localparam logic [DSG_GPIO_N-1:0] DSG_OSC_LOCAL_PINS = 4'hc;
  localparam logic [DSG_GPIO_N-1:0] DSG_NO_LOCAL_PINS  = 4'h0;
  // Rate-limit counter step and unused status bits
  localparam logic [DSG_HOLD_W-1:0] DSG_HOLD_STEP      = 12'h001;
  localparam logic [2:0]            DSG_STATUS_PAD     = 3'h0;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic       ssc_hit;
  logic       status_hit;
  logic [7:0] status_word;

  // Address match for the two mapped registers
  assign ssc_hit    = reg_addr_i == DSG_SSC_CTRL_ADDR;
  assign status_hit = reg_addr_i == DSG_STATUS_ADDR;

  // Status layout: valid flag, mode, link and lock
  assign status_word = {DSG_STATUS_PAD, st_r.mode_valid, st_r.mode, st_r.link_en, st_r.lock};

  // ----------------------------------------------------------------
  // GPIO routing
  // ----------------------------------------------------------------
  logic [DSG_GPIO_N-1:0] local_pins;
  logic [DSG_GPIO_N-1:0] fwd_pins;

  // Oscillator mode claims pins two and three for local values
  assign local_pins = ext_osc_mode_i ? DSG_OSC_LOCAL_PINS : DSG_NO_LOCAL_PINS;
  // A pin forwards only when selected and not claimed
  assign fwd_pins   = gpio_fwd_sel_i & ~local_pins;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic                  pdb_rise;
    logic                  strobe;
    logic [DSG_OUT_W-1:0]  word;
    logic [DSG_OUT_W-1:0]  mask;
    pdb_rise   = 1'b0;
    strobe     = 1'b0;
    word       = '0;
    mask       = '0;
    st_nxt     = st_r;

    // Samples taken every cycle, send pulse dropped
    st_nxt.pdb_q   = powerdown_n_pin_i;
    st_nxt.pclk_q  = pclk_i;
    st_nxt.bc_send = 1'b0;
    pdb_rise       = powerdown_n_pin_i && !st_r.pdb_q;

    if (!powerdown_n_pin_i) begin
      // Power-down: everything released, link off, mode forgotten
      st_nxt           = DSG_STATE_RESET;
      st_nxt.pclk_q    = pclk_i;
      st_nxt.ssc       = st_r.ssc;
    end else begin
      st_nxt.link_en = 1'b1;

      // Strap sampled once at power-down exit and held
      if (pdb_rise) begin
        st_nxt.mode       = dsg_decode_strap(mode_strap_resistor_i);
        st_nxt.mode_valid = 1'b1;
        st_nxt.bc_send    = 1'b1;
      end

      // Register writes
      if (reg_wr_i && ssc_hit) begin
        st_nxt.ssc = reg_wdata_i;
      end

      // Register reads, unmapped reads return zero
      if (reg_rd_i) begin
        if (ssc_hit) begin
          st_nxt.rdata = st_r.ssc;
        end else if (status_hit) begin
          st_nxt.rdata = status_word;
        end else begin
          st_nxt.rdata = DSG_RDATA_NONE;
        end
      end

      // Lock indicator follows the recovered link
      st_nxt.lock      = cdr_locked_i && st_r.mode_valid;

      // Enables drive once powered
      st_nxt.lock_oe_n = 1'b0;
      st_nxt.data_oe_n = 1'b0;

      // Strobe edge select
      if (rx_strobe_edge_sel_i) begin
        strobe = pclk_i && !st_r.pclk_q;
      end else begin
        strobe = !pclk_i && st_r.pclk_q;
      end

      // Output word, driven low until locked
      word = {rx_frame_sync_i, rx_line_sync_i, rx_data_i};
      if (!st_r.lock) begin
        word = '0;
      end
      if (st_r.mode == DSG_MODE_10B) begin
        word[DSG_DATA_W-1:DSG_DATA_W-2] = 2'b00;
      end

      // Staggered update: masked bits land one cycle late
      mask = stagger_en_i ? stagger_mask : '0;
      if (strobe) begin
        st_nxt.outw = (word & ~mask) | (st_r.outw & mask);
        st_nxt.pend = word;
        st_nxt.late = 1'b1;
      end else if (st_r.late) begin
        st_nxt.outw = st_r.pend;
        st_nxt.late = 1'b0;
      end

      for (int i = 0; i < DSG_GPIO_N; i++) begin
        if (fwd_pins[i]) begin
          // Input pin forwarded with rate limit
          st_nxt.gpio_oe_n[i] = 1'b1;
          st_nxt.gpio_out[i]  = 1'b0;
          if (st_r.hold[i] != DSG_HOLD_ZERO) begin
            st_nxt.hold[i] = st_r.hold[i] - DSG_HOLD_STEP;
          end else if (gpio_in_i[i] != st_r.link_gpio[i]) begin
            st_nxt.link_gpio[i] = gpio_in_i[i];
            st_nxt.hold[i]      = DSG_HOLD_LOAD;
          end
        end else begin
          // Local register value driven on the pin
          st_nxt.gpio_oe_n[i] = 1'b0;
          st_nxt.gpio_out[i]  = gpio_local_val_i[i];
          st_nxt.link_gpio[i] = 1'b0;
          st_nxt.hold[i]      = DSG_HOLD_ZERO;
        end
      end
    end

    // Clock ratio registered alongside the mode it follows
    st_nxt.ratio = dsg_mode_ratio(st_nxt.mode);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      st_r <= DSG_STATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs straight from the state register
  // ----------------------------------------------------------------
  // Data of the last register read
  assign reg_rdata_o    = st_r.rdata;

  // GPIO drive and link forwarding
  assign gpio_out_o     = st_r.gpio_out;
  assign gpio_oe_n_o    = st_r.gpio_oe_n;
  assign link_gpio_o    = st_r.link_gpio;

  // Output word split into data and syncs
  assign data_o         = st_r.outw[DSG_DATA_W-1:0];
  assign line_sync_o    = st_r.outw[DSG_DATA_W];
  assign frame_sync_o   = st_r.outw[DSG_DATA_W+1];

  // Output enables and link, released in power-down
  assign data_oe_n_o    = st_r.data_oe_n;
  assign lock_oe_n_o    = st_r.lock_oe_n;
  assign link_enable_o  = st_r.link_en;

  // Lock indicator
  assign lock_o         = st_r.lock;

  // Mode, back-channel request and clock ratio
  assign bc_mode_o      = st_r.mode;
  assign bc_mode_send_o = st_r.bc_send;
  assign clk_ratio_o    = st_r.ratio;

  // Spread-spectrum profile bits
  assign ssc_profile_o  = st_r.ssc[DSG_SSC_PROF_MSB:0];

endmodule // dsg_ctrl

// ===== hdl/dsg_pkg.sv
// Package of constants and types for the deserializer mode, GPIO and output control
package dsg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] DSG_SSC_CTRL_ADDR  = 8'h02;
  localparam logic [7:0] DSG_STATUS_ADDR    = 8'h04;
  localparam logic [7:0] DSG_SSC_CTRL_RESET = 8'h00;
  localparam int         DSG_SSC_PROF_MSB   = 3;
  localparam logic [7:0] DSG_RDATA_NONE     = 8'h00;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DSG_DATA_W  = 12;
  localparam int DSG_OUT_W   = 14;
  localparam int DSG_GPIO_N  = 4;
  localparam int DSG_LFSR_W  = 16;
  localparam logic [DSG_LFSR_W-1:0] DSG_LFSR_SEED = 16'hace1;
  localparam logic [DSG_LFSR_W-1:0] DSG_LFSR_TAPS = 16'hb400;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint DSG_CLK_HZ       = 200000000;
  localparam longint DSG_GPIO_RATE_HZ = 66000;
  localparam int     DSG_GPIO_HOLD_CYC =
    int'((DSG_CLK_HZ + DSG_GPIO_RATE_HZ - 1) / DSG_GPIO_RATE_HZ);
  localparam int     DSG_HOLD_W = 12;
  localparam logic [DSG_HOLD_W-1:0] DSG_HOLD_LOAD = 12'(DSG_GPIO_HOLD_CYC - 1);
  localparam logic [DSG_HOLD_W-1:0] DSG_HOLD_ZERO = 12'h000;

  // ----------------------------------------------------------------
  // Strap codes from the mode resistor comparator
  // ----------------------------------------------------------------
  localparam logic [1:0] DSG_STRAP_0K  = 2'h0;
  localparam logic [1:0] DSG_STRAP_3K  = 2'h1;
  localparam logic [1:0] DSG_STRAP_11K = 2'h2;

  // ----------------------------------------------------------------
  // Modes and clock ratios
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DSG_MODE_12LF = 2'b00,
    DSG_MODE_12HF = 2'b01,
    DSG_MODE_10B  = 2'b10
  } dsg_mode_t;

  typedef enum logic [1:0] {
    DSG_RATIO_DIV1   = 2'b00,
    DSG_RATIO_DIV2   = 2'b01,
    DSG_RATIO_DIV1P5 = 2'b10
  } dsg_ratio_t;

  // Strap level to operating mode
  function automatic dsg_mode_t dsg_decode_strap(input logic [1:0] code);
    dsg_mode_t m;
    m = DSG_MODE_12LF;
    if (code == DSG_STRAP_3K) begin
      m = DSG_MODE_12HF;
    end else if (code == DSG_STRAP_11K) begin
      m = DSG_MODE_10B;
    end
    return m;
  endfunction

  // Mode to internal clock ratio
  function automatic dsg_ratio_t dsg_mode_ratio(input dsg_mode_t m);
    dsg_ratio_t r;
    r = DSG_RATIO_DIV1;
    if (m == DSG_MODE_10B) begin
      r = DSG_RATIO_DIV2;
    end else if (m == DSG_MODE_12HF) begin
      r = DSG_RATIO_DIV1P5;
    end
    return r;
  endfunction

endpackage

// ===== hdl/dsg_stagger_lfsr.sv
// Pseudo-random mask generator for staggered output switching
`timescale 1ns/1ps
module dsg_stagger_lfsr
  import dsg_pkg::*;
(
  input  wire logic                  clock_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  run_i,
  output logic [DSG_OUT_W-1:0]       mask_o
);

  typedef struct packed {
    logic [DSG_LFSR_W-1:0] lfsr;
  } dsg_lfsr_state_t;

  dsg_lfsr_state_t st_r;
  dsg_lfsr_state_t st_nxt;

  // Galois shift while running
  always_comb begin
    st_nxt = st_r;
    if (run_i) begin
      st_nxt.lfsr = {1'b0, st_r.lfsr[DSG_LFSR_W-1:1]};
      if (st_r.lfsr[0]) begin
        st_nxt.lfsr = st_nxt.lfsr ^ DSG_LFSR_TAPS;
      end
    end
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      st_r <= '{lfsr: DSG_LFSR_SEED};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign mask_o = st_r.lfsr[DSG_OUT_W-1:0];

endmodule // dsg_stagger_lfsr

// ===== testbench/dsg_ser_model.sv
// Serializer stand-in driving pixel clock, word and lock status
`timescale 1ns/1ps
module dsg_ser_model
  import dsg_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        pclk_en_i,
  input  wire logic        tx_latch_edge_sel_i,
  input  wire logic        lock_i,
  input  wire logic [13:0] word_i,
  output logic             pclk_o,
  output logic             locked_o,
  output logic [13:0]      word_o
);
  logic [1:0]  div_r = 2'h0;
  logic [13:0] held_r = 14'h0000;

  initial pclk_o = 1'b0;

  // Pixel clock at a fixed ratio, four system cycles per half period
  always @(posedge clock_i) begin
    div_r <= div_r + 2'h1;
    if (pclk_en_i && div_r == 2'h3) begin
      pclk_o <= !pclk_o;
      if (pclk_o != tx_latch_edge_sel_i) begin
        held_r <= word_i;
      end
    end
  end

  // Unlocked link shows garbage, not the last word
  assign locked_o = lock_i;
  assign word_o   = lock_i ? held_r : ~held_r;
endmodule // dsg_ser_model

// ===== testbench/dsg_ctrl_assertions.sv
// Concurrent checks on mode, GPIO, register and power-down outputs
`timescale 1ns/1ps
module dsg_ctrl_assertions
  import dsg_pkg::*;
(
  input wire logic                      clock_i,
  input wire logic                      rst_b_i,
  input wire logic                      powerdown_n_pin_i,
  input wire logic                      ext_osc_mode_i,
  input wire logic [DSG_GPIO_N-1:0]     gpio_fwd_sel_i,
  input wire logic [DSG_GPIO_N-1:0]     gpio_local_val_i,
  input wire logic [7:0]                reg_addr_i,
  input wire logic [7:0]                reg_wdata_i,
  input wire logic                      reg_wr_i,
  input wire logic [DSG_GPIO_N-1:0]     gpio_out_o,
  input wire logic [DSG_GPIO_N-1:0]     gpio_oe_n_o,
  input wire logic                      data_oe_n_o,
  input wire logic                      lock_oe_n_o,
  input wire logic                      link_enable_o,
  input wire logic [1:0]                bc_mode_o,
  input wire logic                      bc_mode_send_o,
  input wire logic [1:0]                clk_ratio_o,
  input wire logic [DSG_SSC_PROF_MSB:0] ssc_profile_o
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_pd_tristate: assert property (
    !powerdown_n_pin_i |=> data_oe_n_o && lock_oe_n_o && &gpio_oe_n_o && !link_enable_o)
    else $error("outputs not released in power-down");
  a_send_pulse: assert property (bc_mode_send_o |=> !bc_mode_send_o)
    else $error("mode send longer than one cycle");
  a_wake_send: assert property ($rose(link_enable_o) |-> bc_mode_send_o)
    else $error("no mode send at link start");
  a_mode_stable: assert property (
    link_enable_o && !bc_mode_send_o |-> $stable(bc_mode_o))
    else $error("mode changed while powered");
  a_ratio_map: assert property (
    clk_ratio_o == (bc_mode_o == 2'h2 ? 2'h1 : bc_mode_o == 2'h1 ? 2'h2 : 2'h0))
    else $error("clock ratio does not match mode");
  a_ssc_write: assert property (
    powerdown_n_pin_i [*3] ##0 reg_wr_i && reg_addr_i == 8'h02
    |=> ssc_profile_o == $past(reg_wdata_i[3:0]))
    else $error("spread profile not taken from write");
  a_local_drive: assert property (
    powerdown_n_pin_i [*3] ##0 !gpio_fwd_sel_i[0]
    |=> !gpio_oe_n_o[0] && gpio_out_o[0] == $past(gpio_local_val_i[0]))
    else $error("local pin value not driven");
  a_osc_local: assert property (
    powerdown_n_pin_i [*3] ##0 ext_osc_mode_i
    |=> gpio_oe_n_o[3:2] == 2'h0 && gpio_out_o[3:2] == $past(gpio_local_val_i[3:2]))
    else $error("pins two and three not local in oscillator mode");

  // Main scenarios reached
  c_send: cover property (bc_mode_send_o);
  c_osc: cover property (ext_osc_mode_i && !gpio_oe_n_o[2]);
  c_wake: cover property ($rose(link_enable_o) ##1 !data_oe_n_o);
endmodule // dsg_ctrl_assertions

bind dsg_ctrl dsg_ctrl_assertions dsg_ctrl_assertions_inst (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .powerdown_n_pin_i(powerdown_n_pin_i),
  .ext_osc_mode_i(ext_osc_mode_i), .gpio_fwd_sel_i(gpio_fwd_sel_i),
  .gpio_local_val_i(gpio_local_val_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .gpio_out_o(gpio_out_o),
  .gpio_oe_n_o(gpio_oe_n_o), .data_oe_n_o(data_oe_n_o), .lock_oe_n_o(lock_oe_n_o),
  .link_enable_o(link_enable_o), .bc_mode_o(bc_mode_o), .bc_mode_send_o(bc_mode_send_o),
  .clk_ratio_o(clk_ratio_o), .ssc_profile_o(ssc_profile_o)
);

// ===== testbench/dsg_ctrl_bench.sv
// Self-checking bench for the mode, GPIO and output controller
`timescale 1ns/1ps
module dsg_ctrl_bench
  import dsg_pkg::*;
();
  logic        clk = 1'b0, rst_b = 1'b0, pdn = 1'b0, ext = 1'b0, rx_sel = 1'b1;
  logic        wr = 1'b0, rd = 1'b0, lock_in = 1'b1, pclk_en = 1'b1;
  logic [1:0]  strap = 2'h0;
  logic [3:0]  gsel = 4'h0, gval = 4'h0, gin = 4'h0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rd_v;
  logic [13:0] word = 14'h0000, rx_word;
  logic [7:0]  rdata;
  logic [3:0]  g_out, g_oe_n, link_g, ssc;
  logic [11:0] dout;
  logic        ls, fs, d_oe_n, lock, l_oe_n, link_en, send, pclk, locked;
  logic [1:0]  mode, ratio;
  logic [1:0]  st_tab [3] = '{2'h2, 2'h1, 2'h0};
  logic [1:0]  md_tab [3] = '{DSG_MODE_10B, DSG_MODE_12HF, DSG_MODE_12LF};
  logic [1:0]  rt_tab [3] = '{2'h1, 2'h2, 2'h0};
  int          errors = 0, n_compared = 0, cyc = 0, n;

  always #2.5 clk = !clk;

  dsg_ser_model dsg_ser_model_inst (.clock_i(clk), .pclk_en_i(pclk_en),
    .tx_latch_edge_sel_i(1'b1), .lock_i(lock_in), .word_i(word), .pclk_o(pclk),
    .locked_o(locked), .word_o(rx_word));

  dsg_ctrl dsg_ctrl_inst (.clock_i(clk), .rst_b_i(rst_b), .powerdown_n_pin_i(pdn),
    .mode_strap_resistor_i(strap), .ext_osc_mode_i(ext), .cdr_locked_i(locked),
    .pclk_i(pclk), .rx_data_i(rx_word[11:0]), .rx_line_sync_i(rx_word[12]),
    .rx_frame_sync_i(rx_word[13]), .rx_strobe_edge_sel_i(rx_sel), .stagger_en_i(1'b1),
    .gpio_fwd_sel_i(gsel), .gpio_local_val_i(gval), .gpio_in_i(gin), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .gpio_out_o(g_out), .gpio_oe_n_o(g_oe_n), .link_gpio_o(link_g), .data_o(dout),
    .line_sync_o(ls), .frame_sync_o(fs), .data_oe_n_o(d_oe_n), .lock_o(lock),
    .lock_oe_n_o(l_oe_n), .link_enable_o(link_en), .bc_mode_o(mode),
    .bc_mode_send_o(send), .clk_ratio_o(ratio), .ssc_profile_o(ssc));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic cmp(input string what, input logic [15:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask

  // New word latched on a pixel clock rise, output looked at before the fall
  task automatic strobe(input logic s, input logic [13:0] w, e);
    @(negedge clk);
    rx_sel = s;
    word = w;
    @(posedge pclk);
    repeat (3) @(posedge clk);
    @(negedge clk);
    cmp("word", 16'(e), 16'({fs, ls, dout}));
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    // Power cycle through every strap code
    for (int i = 0; i < 3; i++) begin
      @(negedge clk);
      pdn = 1'b0;
      strap = st_tab[i];
      repeat (2) @(negedge clk);
      cmp("oe_n", 16'h003f, 16'({d_oe_n, l_oe_n, g_oe_n}));
      cmp("link_en", 16'h0000, 16'(link_en));
      pdn = 1'b1;
      for (n = 0; n < 8 && send !== 1'b1; n++) @(negedge clk);
      cmp("send", 16'h0001, 16'(send));
      cmp("mode", 16'(md_tab[i]), 16'(mode));
      cmp("ratio", 16'(rt_tab[i]), 16'(ratio));
      strap = 2'h1;
      repeat (4) @(negedge clk);
      cmp("held mode", 16'(md_tab[i]), 16'(mode));
      cmp("link_en", 16'h0001, 16'(link_en));
    end
    lock_in = 1'b0;
    repeat (3) @(negedge clk);
    cmp("lock", 16'h0000, 16'(lock));
    lock_in = 1'b1;
    // Data bits 11 and 10 pass only in twelve-bit mode, as here
    strobe(1'b1, 14'h2a5c, 14'h2a5c);
    strobe(1'b0, 14'h15a3, 14'h2a5c);
    repeat (8) @(negedge clk);
    cmp("word", 16'h15a3, 16'({fs, ls, dout}));
    cmp("lock", 16'h0001, 16'(lock));
    reg_read(8'h02, rd_v);
    cmp("ssc reset", 16'(DSG_SSC_CTRL_RESET), 16'(rd_v));
    reg_write(8'h02, 8'h3a);
    cmp("ssc profile", 16'h000a, 16'(ssc));
    reg_read(8'h02, rd_v);
    cmp("ssc read", 16'h003a, 16'(rd_v));
    reg_read(8'h40, rd_v);
    cmp("unmapped", 16'h0000, 16'(rd_v));
    reg_read(8'h04, rd_v);
    cmp("status", 16'h0013, 16'(rd_v));
    gsel = 4'h3;
    gval = 4'hc;
    repeat (2) @(negedge clk);
    cmp("gpio oe_n", 16'h0003, 16'(g_oe_n));
    cmp("gpio out", 16'h0003, 16'(g_out[3:2]));
    gin[0] = 1'b1;
    repeat (2) @(negedge clk);
    cmp("link gpio", 16'h0001, 16'(link_g[0]));
    gin[0] = 1'b0;
    repeat (100) @(negedge clk);
    cmp("link gpio held", 16'h0001, 16'(link_g[0]));
    repeat (3000) @(negedge clk);
    cmp("link gpio late", 16'h0000, 16'(link_g[0]));
    gsel = 4'hf;
    gval = 4'h8;
    ext = 1'b1;
    repeat (2) @(negedge clk);
    cmp("osc oe_n", 16'h0003, 16'(g_oe_n));
    cmp("osc out", 16'h0002, 16'(g_out[3:2]));
    ext = 1'b0;
    repeat (2) @(negedge clk);
    cmp("four inputs", 16'h000f, 16'(g_oe_n));
    tally_and_finish();
  end
endmodule // dsg_ctrl_bench
